/* sdcd_pkg.sv */
package sdcd_pkg;
  // ----------------------------------------
  // Bus widths and codes
  // ----------------------------------------
  localparam int unsigned CA_W = 6;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned NUM_BANKS = 8;
  // First-edge opcodes on cmd_addr_bus[4:0]
  localparam logic [4:0] OP_MPC = 5'h00;
  localparam logic [4:0] OP_CLOSE = 5'h10;
  localparam logic [4:0] OP_RESTORE = 5'h08;
  localparam logic [4:0] OP_SR_ENTRY = 5'h18;
  localparam logic [4:0] OP_WRITE = 5'h04;
  localparam logic [4:0] OP_SR_EXIT = 5'h14;
  localparam logic [4:0] OP_MWRITE = 5'h0c;
  localparam logic [4:0] OP_READ = 5'h02;
  localparam logic [4:0] OP_COL2 = 5'h12;
  localparam logic [4:0] OP_SWR1 = 5'h06;
  localparam logic [4:0] OP_SWR2 = 5'h16;
  localparam logic [4:0] OP_SRD1 = 5'h0e;
  // Row open uses bits 1:0
  localparam logic [1:0] OP_ROW1 = 2'h1;
  localparam logic [1:0] OP_ROW2 = 2'h3;
  // MULTI_PURPOSE_CMD opcodes needing a column second half (FIFO / calibration reads)
  localparam logic [6:0] MPC_RDFIFO = 7'h41;
  localparam logic [6:0] MPC_RDDQCAL = 7'h43;
  localparam logic [6:0] MPC_WRFIFO = 7'h47;
  // Idle slots required after oscillator / impedance MULTI_PURPOSE_CMD
  localparam int unsigned MPC_IDLE_SLOTS = 2;
  // Extra clocks before clock stop
  localparam int unsigned STOP_EXTRA_CLKS = 4;
  // Ready delay after clock restart
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PD_EXIT_NS = 8;
  localparam int unsigned PD_EXIT_MIN_CK = 5;
  localparam int unsigned PD_EXIT_CYC_NS = (PD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PD_EXIT_CYC =
    (PD_EXIT_CYC_NS > PD_EXIT_MIN_CK) ? PD_EXIT_CYC_NS : PD_EXIT_MIN_CK;
  localparam int unsigned READY_CYC = 2 + PD_EXIT_CYC;

  // Decoded command kinds
  typedef enum logic [4:0] {
    SDCD_CMD_NONE = 5'h00,
    SDCD_CMD_CLOSE = 5'h01,
    SDCD_CMD_RESTORE = 5'h02,
    SDCD_CMD_SR_ENTRY = 5'h03,
    SDCD_CMD_SR_EXIT = 5'h04,
    SDCD_CMD_WRITE = 5'h05,
    SDCD_CMD_MWRITE = 5'h06,
    SDCD_CMD_READ = 5'h07,
    SDCD_CMD_SET_READ = 5'h08,
    SDCD_CMD_SET_WRITE = 5'h09,
    SDCD_CMD_MPC = 5'h0a,
    SDCD_CMD_ROW_OPEN = 5'h0b
  } sdcd_cmd_t;
endpackage : sdcd_pkg

/* sdcd_if.sv */
`timescale 1ns/10ps
interface sdcd_if;
  logic cke;
  logic cs;
  logic [5:0] cmd_addr_bus;
  logic clk_true;
  logic clk_comp;
  modport dev (input cke, input cs, input cmd_addr_bus, input clk_true, input clk_comp);
  modport ctl (output cke, output cs, output cmd_addr_bus, output clk_true, output clk_comp);
endinterface : sdcd_if

/* sdcd_ctl.sv */
`timescale 1ns/10ps
module sdcd_ctl (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Async reset, high
  sdcd_if.ctl bus, // Link to device
  input wire logic i_req_valid, // Command request
  output logic o_req_ready, // Request taken
  input wire logic [4:0] i_req_kind, // sdcd_cmd_t code
  input wire logic [2:0] i_req_bank, // Bank
  input wire logic i_req_all, // All-banks flag
  input wire logic i_req_auto_close, // Auto close flag
  input wire logic i_req_burst32, // Burst size select
  input wire logic [6:0] i_req_op, // MULTI_PURPOSE_CMD opcode / setting data
  input wire logic [5:0] i_req_addr, // Setting address / column 9:4
  input wire logic i_stop_req, // Request clock stop
  output logic o_clk_stopped // Clock held stopped
);
  typedef enum logic [2:0] {
    SDCD_C_IDLE = 3'h0,
    SDCD_C_SECOND = 3'h1,
    SDCD_C_GAP = 3'h3,
    SDCD_C_DRAIN = 3'h2,
    SDCD_C_STOP = 3'h6
  } sdcd_cst_t;

  sdcd_cst_t state_ff, nxt_state;
  logic [5:0] ca_ff, nxt_ca;
  logic cs_ff, nxt_cs;
  logic [5:0] hold_ff, nxt_hold;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [1:0] sub_ff, nxt_sub;
  logic clk_out_ff, nxt_clk_out;
  logic [5:0] ca1, ca2;
  logic two;
  sdcd_pkg::sdcd_cmd_t kind;

  // ----------------------------------------
  // Command encoding
  // ----------------------------------------
  // Builds both halves; second half of column commands rides in hold
  always_comb begin
    kind = sdcd_pkg::sdcd_cmd_t'(i_req_kind);
    ca1 = 6'h00;
    ca2 = 6'h00;
    two = 1'b0;
    case (kind)
      sdcd_pkg::SDCD_CMD_CLOSE: begin
        ca1 = {i_req_all, sdcd_pkg::OP_CLOSE};
        ca2 = {3'h0, i_req_bank};
      end
      sdcd_pkg::SDCD_CMD_RESTORE: begin
        ca1 = {i_req_all, sdcd_pkg::OP_RESTORE};
        ca2 = {3'h0, i_req_bank};
      end
      sdcd_pkg::SDCD_CMD_SR_ENTRY: ca1 = {1'b0, sdcd_pkg::OP_SR_ENTRY};
      sdcd_pkg::SDCD_CMD_SR_EXIT: ca1 = {1'b0, sdcd_pkg::OP_SR_EXIT};
      sdcd_pkg::SDCD_CMD_WRITE: begin
        ca1 = {i_req_burst32, sdcd_pkg::OP_WRITE};
        ca2 = {i_req_auto_close, i_req_addr[5], 1'b0, i_req_bank};
        two = 1'b1;
      end
      sdcd_pkg::SDCD_CMD_MWRITE: begin
        ca1 = {1'b0, sdcd_pkg::OP_MWRITE};
        ca2 = {i_req_auto_close, i_req_addr[5], 1'b0, i_req_bank};
        two = 1'b1;
      end
      sdcd_pkg::SDCD_CMD_READ: begin
        ca1 = {i_req_burst32, sdcd_pkg::OP_READ};
        ca2 = {i_req_auto_close, i_req_addr[5], 1'b0, i_req_bank};
        two = 1'b1;
      end
      sdcd_pkg::SDCD_CMD_SET_READ: begin
        ca1 = {1'b0, sdcd_pkg::OP_SRD1};
        ca2 = i_req_addr;
        two = 1'b1;
      end
      sdcd_pkg::SDCD_CMD_SET_WRITE: begin
        ca1 = {i_req_op[6], sdcd_pkg::OP_SWR1};
        ca2 = i_req_addr;
        two = 1'b1;
      end
      sdcd_pkg::SDCD_CMD_MPC: begin
        ca1 = {i_req_op[6], sdcd_pkg::OP_MPC};
        ca2 = i_req_op[5:0];
        two = (i_req_op == sdcd_pkg::MPC_RDFIFO) || (i_req_op == sdcd_pkg::MPC_RDDQCAL) ||
              (i_req_op == sdcd_pkg::MPC_WRFIFO);
      end
      sdcd_pkg::SDCD_CMD_ROW_OPEN: begin
        ca1 = {i_req_addr[5:2], sdcd_pkg::OP_ROW1};
        ca2 = {i_req_addr[1:0], 1'b0, i_req_bank};
        two = 1'b1;
      end
      default: begin
        ca1 = 6'h00;
        ca2 = 6'h00;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Idle takes a request; pairs halves back to back
  always_comb begin
    nxt_state = state_ff;
    nxt_ca = 6'h00;
    nxt_cs = 1'b0;
    nxt_hold = hold_ff;
    nxt_cnt = cnt_ff;
    nxt_sub = sub_ff;
    nxt_clk_out = ~clk_out_ff;
    o_req_ready = 1'b0;
    case (state_ff)
      SDCD_C_IDLE: begin
        if (i_stop_req) begin
          nxt_cnt = 3'(sdcd_pkg::STOP_EXTRA_CLKS);
          nxt_state = SDCD_C_DRAIN;
        end else if (i_req_valid && kind != sdcd_pkg::SDCD_CMD_NONE) begin
          o_req_ready = 1'b1;
          nxt_cs = 1'b1;
          nxt_ca = ca1;
          nxt_hold = ca2;
          nxt_sub = 2'(two ? 2'h2 : 2'h1);
          if (kind == sdcd_pkg::SDCD_CMD_MPC && !two) begin
            nxt_cnt = 3'(sdcd_pkg::MPC_IDLE_SLOTS);
          end else begin
            nxt_cnt = 3'h0;
          end
          nxt_state = SDCD_C_SECOND;
        end
      end
      SDCD_C_SECOND: begin
        nxt_ca = hold_ff;
        if (sub_ff == 2'h2) begin
          nxt_sub = 2'h3;
        end else if (sub_ff == 2'h3) begin
          nxt_ca = kind == sdcd_pkg::SDCD_CMD_ROW_OPEN ? {i_req_addr[5:2], sdcd_pkg::OP_ROW2}
                   : {i_req_addr[4], sdcd_pkg::OP_COL2};
          if (kind == sdcd_pkg::SDCD_CMD_SET_WRITE) begin
            nxt_ca = {i_req_op[6], sdcd_pkg::OP_SWR2};
          end
          nxt_cs = 1'b1;
          nxt_hold = kind == sdcd_pkg::SDCD_CMD_SET_WRITE ? i_req_op[5:0] :
                     kind == sdcd_pkg::SDCD_CMD_ROW_OPEN ? i_req_addr : {i_req_addr[3:0], 2'h0};
          nxt_sub = 2'h1;
        end else begin
          nxt_state = cnt_ff != 3'h0 ? SDCD_C_GAP : SDCD_C_IDLE;
        end
      end
      SDCD_C_GAP: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h1) begin
          nxt_state = SDCD_C_IDLE;
        end
      end
      SDCD_C_DRAIN: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h1) begin
          nxt_state = SDCD_C_STOP;
        end
      end
      SDCD_C_STOP: begin
        nxt_clk_out = 1'b0;
        if (!i_stop_req) begin
          nxt_state = SDCD_C_IDLE;
        end
      end
      default: nxt_state = SDCD_C_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= SDCD_C_IDLE;
      ca_ff <= 6'h00;
      cs_ff <= 1'b0;
      hold_ff <= 6'h00;
      cnt_ff <= 3'h0;
      sub_ff <= 2'h0;
      clk_out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ca_ff <= nxt_ca;
      cs_ff <= nxt_cs;
      hold_ff <= nxt_hold;
      cnt_ff <= nxt_cnt;
      sub_ff <= nxt_sub;
      clk_out_ff <= nxt_clk_out;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // clock enable high
  assign bus.cke = 1'b1;
  assign bus.cs = cs_ff;
  assign bus.cmd_addr_bus = ca_ff;
  assign bus.clk_true = clk_out_ff;
  assign bus.clk_comp = ~clk_out_ff;
  assign o_clk_stopped = (state_ff == SDCD_C_STOP);
endmodule : sdcd_ctl

/* sdcd_dev.sv */
`timescale 1ns/10ps
module sdcd_dev #(
  parameter int unsigned READY_CYCLES = sdcd_pkg::READY_CYC
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Async reset, high
  sdcd_if.dev bus, // Link from controller
  input wire logic i_otf_burst_en, // On-the-fly burst enable
  output logic o_cmd_valid, // Decoded command pulse
  output sdcd_pkg::sdcd_cmd_t o_cmd_kind, // Command kind
  output logic [7:0] o_cmd_banks, // Banks acted upon
  output logic o_auto_close, // Close after access
  output logic o_burst32, // Burst length 32
  output logic [9:0] o_column, // Column address
  output logic [16:0] o_row, // Row address
  output logic [5:0] o_set_addr, // Setting address
  output logic [7:0] o_set_data, // Setting data / MULTI_PURPOSE_CMD op
  output logic o_seq_error, // Pairing violation, sticky
  output logic o_ready // Ready for normal operation
);
  typedef enum logic [1:0] {
    SDCD_D_FIRST = 2'h0,
    SDCD_D_SECOND = 2'h1,
    SDCD_D_WAIT_COL = 2'h3,
    SDCD_D_WAIT_PAIR = 2'h2
  } sdcd_dst_t;

  sdcd_dst_t state_ff, nxt_state;
  logic [5:0] r1_ff, nxt_r1;
  logic [5:0] prev_ff, nxt_prev;
  logic [4:0] col_ff, nxt_col;
  sdcd_pkg::sdcd_cmd_t kind_ff, nxt_kind;
  logic err_ff, nxt_err;
  logic valid_ff, nxt_valid;
  sdcd_pkg::sdcd_cmd_t okind_ff, nxt_okind;
  logic [7:0] banks_ff, nxt_banks;
  logic ac_ff, nxt_ac, b32_ff, nxt_b32;
  logic [9:0] colo_ff, nxt_colo;
  logic [16:0] row_ff, nxt_row;
  logic [5:0] sa_ff, nxt_sa;
  logic [7:0] sd_ff, nxt_sd;
  logic [1:0] idle_ff, nxt_idle;
  logic [15:0] rdy_ff, nxt_rdy;
  logic prev_clk_ff;
  sdcd_pkg::sdcd_cmd_t k1;
  logic [5:0] ca;
  logic [6:0] mop;

  assign ca = bus.cmd_addr_bus;

  // ----------------------------------------
  // First-edge decode
  // ----------------------------------------
  // first-edge opcode table; row open matched on bits 1:0
  always_comb begin
    case (r1_ff[4:0])
      sdcd_pkg::OP_MPC: k1 = sdcd_pkg::SDCD_CMD_MPC;
      sdcd_pkg::OP_CLOSE: k1 = sdcd_pkg::SDCD_CMD_CLOSE;
      sdcd_pkg::OP_RESTORE: k1 = sdcd_pkg::SDCD_CMD_RESTORE;
      sdcd_pkg::OP_SR_ENTRY: k1 = sdcd_pkg::SDCD_CMD_SR_ENTRY;
      sdcd_pkg::OP_WRITE: k1 = sdcd_pkg::SDCD_CMD_WRITE;
      sdcd_pkg::OP_SR_EXIT: k1 = sdcd_pkg::SDCD_CMD_SR_EXIT;
      sdcd_pkg::OP_MWRITE: k1 = sdcd_pkg::SDCD_CMD_MWRITE;
      sdcd_pkg::OP_READ: k1 = sdcd_pkg::SDCD_CMD_READ;
      sdcd_pkg::OP_SWR1: k1 = sdcd_pkg::SDCD_CMD_SET_WRITE;
      sdcd_pkg::OP_SRD1: k1 = sdcd_pkg::SDCD_CMD_SET_READ;
      default: k1 = sdcd_pkg::SDCD_CMD_NONE;
    endcase
    if (r1_ff[1:0] == sdcd_pkg::OP_ROW1) begin
      k1 = sdcd_pkg::SDCD_CMD_ROW_OPEN;
    end
    mop = {r1_ff[5], ca};
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_r1 = r1_ff;
    nxt_prev = prev_ff;
    nxt_col = col_ff;
    nxt_kind = kind_ff;
    nxt_err = err_ff;
    nxt_valid = 1'b0;
    nxt_okind = okind_ff;
    nxt_banks = banks_ff;
    nxt_ac = ac_ff;
    nxt_b32 = b32_ff;
    nxt_colo = colo_ff;
    nxt_row = row_ff;
    nxt_sa = sa_ff;
    nxt_sd = sd_ff;
    nxt_idle = idle_ff;
    case (state_ff)
      SDCD_D_FIRST: begin
        if (bus.cs) begin
          if (idle_ff != 2'h0) begin
            nxt_err = 1'b1;
          end
          if (ca[4:0] == sdcd_pkg::OP_COL2 || ca[1:0] == sdcd_pkg::OP_ROW2 || ca[4:0] == sdcd_pkg::OP_SWR2) begin
            nxt_err = 1'b1;
          end
          nxt_r1 = ca;
          nxt_state = SDCD_D_SECOND;
        end else if (idle_ff != 2'h0) begin
          nxt_idle = idle_ff - 2'h1;
        end
      end
      SDCD_D_SECOND: begin
        nxt_state = SDCD_D_FIRST;
        nxt_kind = k1;
        nxt_prev = ca;
        nxt_banks = 8'h01 << ca[2:0];
        case (k1)
          sdcd_pkg::SDCD_CMD_CLOSE, sdcd_pkg::SDCD_CMD_RESTORE: begin
            if (r1_ff[5]) begin
              nxt_banks = 8'hff;
            end
            nxt_okind = k1;
            nxt_valid = 1'b1;
          end
          sdcd_pkg::SDCD_CMD_SR_ENTRY, sdcd_pkg::SDCD_CMD_SR_EXIT: begin
            nxt_okind = k1;
            nxt_valid = 1'b1;
          end
          sdcd_pkg::SDCD_CMD_WRITE, sdcd_pkg::SDCD_CMD_MWRITE, sdcd_pkg::SDCD_CMD_READ: begin
            nxt_ac = ca[5];
            nxt_b32 = i_otf_burst_en && r1_ff[5] && k1 != sdcd_pkg::SDCD_CMD_MWRITE;
            nxt_colo[9] = ca[4];
            nxt_state = SDCD_D_WAIT_COL;
          end
          sdcd_pkg::SDCD_CMD_SET_READ: begin
            nxt_sa = ca;
            nxt_state = SDCD_D_WAIT_COL;
          end
          sdcd_pkg::SDCD_CMD_MPC: begin
            nxt_sd = {1'b0, mop};
            if (mop == sdcd_pkg::MPC_RDFIFO || mop == sdcd_pkg::MPC_RDDQCAL || mop == sdcd_pkg::MPC_WRFIFO) begin
              nxt_state = SDCD_D_WAIT_COL;
            end else begin
              nxt_okind = k1;
              nxt_valid = 1'b1;
              nxt_idle = 2'(sdcd_pkg::MPC_IDLE_SLOTS);
            end
          end
          sdcd_pkg::SDCD_CMD_SET_WRITE, sdcd_pkg::SDCD_CMD_ROW_OPEN: begin
            nxt_state = SDCD_D_WAIT_PAIR;
          end
          default: ;
        endcase
      end
      SDCD_D_WAIT_COL, SDCD_D_WAIT_PAIR: begin
        if (!bus.cs) begin
          nxt_err = 1'b1;
          nxt_state = SDCD_D_FIRST;
        end else begin
          nxt_r1 = ca;
          nxt_col = {ca[5], 4'h0};
          if (state_ff == SDCD_D_WAIT_COL && ca[4:0] != sdcd_pkg::OP_COL2) begin
            nxt_err = 1'b1;
          end
          if (kind_ff == sdcd_pkg::SDCD_CMD_ROW_OPEN && ca[1:0] != sdcd_pkg::OP_ROW2) begin
            nxt_err = 1'b1;
          end
          if (kind_ff == sdcd_pkg::SDCD_CMD_SET_WRITE && ca[4:0] != sdcd_pkg::OP_SWR2) begin
            nxt_err = 1'b1;
          end
          nxt_state = SDCD_D_SECOND;
        end
      end
      default: nxt_state = SDCD_D_FIRST;
    endcase
    // Second half of a pair completes here
    if (state_ff == SDCD_D_SECOND && (r1_ff[4:0] == sdcd_pkg::OP_COL2 || r1_ff[1:0] == sdcd_pkg::OP_ROW2 ||
        r1_ff[4:0] == sdcd_pkg::OP_SWR2) && kind_ff != sdcd_pkg::SDCD_CMD_NONE && !err_ff) begin
      nxt_state = SDCD_D_FIRST;
      nxt_valid = 1'b1;
      nxt_okind = kind_ff;
      nxt_banks = banks_ff;
      if (kind_ff == sdcd_pkg::SDCD_CMD_ROW_OPEN) begin
        nxt_row = {r1_ff[5:2], prev_ff[5:4], r1_ff[5:2], ca[5:0], 1'b0};
      end else if (kind_ff == sdcd_pkg::SDCD_CMD_SET_WRITE) begin
        nxt_sd = {prev_ff[5], r1_ff[5], ca};
        nxt_sa = prev_ff;
      end else begin
        nxt_colo = {colo_ff[9], col_ff[4], ca, 2'h0};
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= SDCD_D_FIRST;
      r1_ff <= 6'h00;
      prev_ff <= 6'h00;
      col_ff <= 5'h00;
      kind_ff <= sdcd_pkg::SDCD_CMD_NONE;
      err_ff <= 1'b0;
      valid_ff <= 1'b0;
      okind_ff <= sdcd_pkg::SDCD_CMD_NONE;
      banks_ff <= 8'h00;
      ac_ff <= 1'b0;
      b32_ff <= 1'b0;
      colo_ff <= 10'h000;
      row_ff <= 17'h00000;
      sa_ff <= 6'h00;
      sd_ff <= 8'h00;
      idle_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      r1_ff <= nxt_r1;
      prev_ff <= nxt_prev;
      col_ff <= nxt_col;
      kind_ff <= nxt_kind;
      err_ff <= nxt_err;
      valid_ff <= nxt_valid;
      okind_ff <= nxt_okind;
      banks_ff <= nxt_banks;
      ac_ff <= nxt_ac;
      b32_ff <= nxt_b32;
      colo_ff <= nxt_colo;
      row_ff <= nxt_row;
      sa_ff <= nxt_sa;
      sd_ff <= nxt_sd;
      idle_ff <= nxt_idle;
    end
  end

  // ----------------------------------------
  // Ready after clock restart
  // ----------------------------------------
  // ready count
  always_comb begin
    nxt_rdy = rdy_ff;
    if (!bus.clk_true && bus.clk_comp && prev_clk_ff == 1'b0) begin
      nxt_rdy = 16'(READY_CYCLES);
    end else if (rdy_ff != 16'h0000) begin
      nxt_rdy = rdy_ff - 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdy_ff <= 16'h0000;
      prev_clk_ff <= 1'b1;
    end else begin
      rdy_ff <= nxt_rdy;
      prev_clk_ff <= bus.clk_true;
    end
  end

  assign o_cmd_valid = valid_ff;
  assign o_cmd_kind = okind_ff;
  assign o_cmd_banks = banks_ff;
  assign o_auto_close = ac_ff;
  assign o_burst32 = b32_ff;
  assign o_column = colo_ff;
  assign o_row = row_ff;
  assign o_set_addr = sa_ff;
  assign o_set_data = sd_ff;
  assign o_seq_error = err_ff;
  assign o_ready = (rdy_ff == 16'h0000);
endmodule : sdcd_dev

/* sdcd_props.sv */
`timescale 1ns/10ps
module sdcd_props (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Async reset, high
  input wire logic cke, // Clock enable
  input wire logic cs, // Chip select
  input wire logic [5:0] cmd_addr_bus, // Command bus
  input wire logic clk_true, // Link clock
  input wire logic clk_comp // Link clock complement
);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [4:0] op;
  logic col1;
  // First-edge opcode and column first halves
  assign op = cmd_addr_bus[4:0];
  assign col1 = (op == sdcd_pkg::OP_WRITE) || (op == sdcd_pkg::OP_MWRITE) || (op == sdcd_pkg::OP_READ) ||
    (op == sdcd_pkg::OP_SRD1) || (op == sdcd_pkg::OP_MPC && cmd_addr_bus[5]);
  property p_two_edge; cs |=> !cs; endproperty
  a_two_edge: assert property (p_two_edge) else $error("cs high on two edges in a row");
  property p_cke_hi; cs |-> cke; endproperty
  a_cke_hi: assert property (p_cke_hi) else $error("command with cke low");
  property p_mw_bl; cs && op == sdcd_pkg::OP_MWRITE |-> !cmd_addr_bus[5]; endproperty
  a_mw_bl: assert property (p_mw_bl) else $error("masked write line 5 high");
  property p_col_pair; cs && col1 |-> ##2 cs && op == sdcd_pkg::OP_COL2; endproperty
  a_col_pair: assert property (p_col_pair) else $error("column second half missing");
  property p_swr_pair; cs && op == sdcd_pkg::OP_SWR1 |-> ##2 cs && op == sdcd_pkg::OP_SWR2; endproperty
  a_swr_pair: assert property (p_swr_pair) else $error("setting write second half missing");
  property p_row_pair;
    cs && cmd_addr_bus[1:0] == sdcd_pkg::OP_ROW1 |-> ##2 cs && cmd_addr_bus[1:0] == sdcd_pkg::OP_ROW2;
  endproperty
  a_row_pair: assert property (p_row_pair) else $error("row open second half missing");
  property p_wr_c32;
    cs && (op == sdcd_pkg::OP_WRITE || op == sdcd_pkg::OP_MWRITE) ##2 cs |=> cmd_addr_bus[1:0] == 2'h0;
  endproperty
  a_wr_c32: assert property (p_wr_c32) else $error("write column bits 3:2 not low");
  property p_mpc_idle; cs && op == sdcd_pkg::OP_MPC && !cmd_addr_bus[5] |=> ##1 !cs [*2]; endproperty
  a_mpc_idle: assert property (p_mpc_idle) else $error("idle slots after mpc missing");
  property p_stop; !clk_true [*3] |-> !cs && clk_comp; endproperty
  a_stop: assert property (p_stop) else $error("stopped clock with cs or comp wrong");
endmodule : sdcd_props

/* tb.sv */
`timescale 1ns/10ps
module tb;
  logic i_ref_clk;
  logic i_rst;
  logic i_req_valid;
  logic [4:0] i_req_kind;
  logic [2:0] i_req_bank;
  logic i_req_all;
  logic i_req_auto_close;
  logic i_req_burst32;
  logic [6:0] i_req_op;
  logic [5:0] i_req_addr;
  logic i_stop_req;
  logic i_otf_burst_en;
  logic o_req_ready;
  logic o_clk_stopped;
  logic o_cmd_valid;
  sdcd_pkg::sdcd_cmd_t o_cmd_kind;
  logic [7:0] o_cmd_banks;
  logic o_auto_close;
  logic o_burst32;
  logic [9:0] o_column;
  logic [5:0] o_set_addr;
  logic [7:0] o_set_data;
  logic o_seq_error;
  logic o_ready;
  int n_errors = 0;
  int n_checks = 0;
  int n;
  sdcd_if u_sdcd_if();
  sdcd_ctl u_sdcd_ctl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(u_sdcd_if), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req_kind(i_req_kind), .i_req_bank(i_req_bank), .i_req_all(i_req_all),
    .i_req_auto_close(i_req_auto_close), .i_req_burst32(i_req_burst32), .i_req_op(i_req_op),
    .i_req_addr(i_req_addr), .i_stop_req(i_stop_req), .o_clk_stopped(o_clk_stopped));
  sdcd_dev u_sdcd_dev (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(u_sdcd_if), .i_otf_burst_en(i_otf_burst_en),
    .o_cmd_valid(o_cmd_valid), .o_cmd_kind(o_cmd_kind), .o_cmd_banks(o_cmd_banks), .o_auto_close(o_auto_close),
    .o_burst32(o_burst32), .o_column(o_column), .o_row(), .o_set_addr(o_set_addr), .o_set_data(o_set_data),
    .o_seq_error(o_seq_error), .o_ready(o_ready));
  sdcd_props u_sdcd_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .cke(u_sdcd_if.cke), .cs(u_sdcd_if.cs),
    .cmd_addr_bus(u_sdcd_if.cmd_addr_bus), .clk_true(u_sdcd_if.clk_true), .clk_comp(u_sdcd_if.clk_comp));
  // Clock, 100 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Issue one request at a falling edge, wait for the decoded pulse
  task automatic send(input sdcd_pkg::sdcd_cmd_t k, input logic [2:0] b, input logic ab, input logic ap,
    input logic b32, input logic [6:0] op, input logic [5:0] ad);
    int w;
    i_req_kind = k;
    i_req_bank = b;
    i_req_all = ab;
    i_req_auto_close = ap;
    i_req_burst32 = b32;
    i_req_op = op;
    i_req_addr = ad;
    i_req_valid = 1'b1;
    w = 0;
    #1;
    while (o_req_ready !== 1'b1 && w < 50) begin
      @(negedge i_ref_clk);
      #1;
      w++;
    end
    @(negedge i_ref_clk);
    i_req_valid = 1'b0;
    w = 0;
    while (o_cmd_valid !== 1'b1 && w < 20) begin
      @(negedge i_ref_clk);
      w++;
    end
    chk(o_cmd_valid, 1, "decode pulse");
    chk(o_cmd_kind, k, "kind");
  endtask : send
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog at 3000 cycles, far beyond the expected 90 or so cycles
  initial begin
    #(3000 * 100);
    n_errors++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rst = 1'b1;
    i_req_valid = 1'b0;
    i_req_kind = 5'h00;
    i_req_bank = 3'h0;
    i_req_all = 1'b0;
    i_req_auto_close = 1'b0;
    i_req_burst32 = 1'b0;
    i_req_op = 7'h00;
    i_req_addr = 6'h00;
    i_stop_req = 1'b0;
    i_otf_burst_en = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    send(sdcd_pkg::SDCD_CMD_CLOSE, 3'h5, 1'b0, 1'b0, 1'b0, 7'h00, 6'h00);
    chk(o_cmd_banks, 8'h20, "close bank");
    send(sdcd_pkg::SDCD_CMD_RESTORE, 3'h2, 1'b1, 1'b0, 1'b0, 7'h00, 6'h00);
    chk(o_cmd_banks, 8'hff, "restore all");
    send(sdcd_pkg::SDCD_CMD_SR_ENTRY, 3'h0, 1'b0, 1'b0, 1'b0, 7'h00, 6'h00);
    send(sdcd_pkg::SDCD_CMD_SR_EXIT, 3'h0, 1'b0, 1'b0, 1'b0, 7'h00, 6'h00);
    send(sdcd_pkg::SDCD_CMD_WRITE, 3'h6, 1'b0, 1'b1, 1'b1, 7'h00, 6'h2a);
    chk({o_cmd_banks, o_auto_close, o_burst32}, {8'h40, 2'h3}, "write flags");
    chk(o_column, 10'h2a0, "write column");
    send(sdcd_pkg::SDCD_CMD_MWRITE, 3'h1, 1'b0, 1'b0, 1'b1, 7'h00, 6'h15);
    chk({o_cmd_banks, o_burst32, o_column}, {8'h02, 1'b0, 10'h150}, "masked write");
    send(sdcd_pkg::SDCD_CMD_READ, 3'h7, 1'b0, 1'b0, 1'b0, 7'h00, 6'h3f);
    chk({o_cmd_banks, o_auto_close, o_burst32, o_column}, {8'h80, 2'h0, 10'h3f0}, "read");
    i_otf_burst_en = 1'b0;
    send(sdcd_pkg::SDCD_CMD_READ, 3'h0, 1'b0, 1'b1, 1'b1, 7'h00, 6'h01);
    chk({o_auto_close, o_burst32}, 2'h2, "read fixed burst");
    send(sdcd_pkg::SDCD_CMD_SET_WRITE, 3'h0, 1'b0, 1'b0, 1'b0, 7'h5a, 6'h0d);
    chk(o_set_addr, 6'h0d, "setting address");
    send(sdcd_pkg::SDCD_CMD_SET_READ, 3'h0, 1'b0, 1'b0, 1'b0, 7'h00, 6'h22);
    chk(o_set_addr, 6'h22, "setting read address");
    send(sdcd_pkg::SDCD_CMD_MPC, 3'h0, 1'b0, 1'b0, 1'b0, sdcd_pkg::MPC_RDFIFO, 6'h00);
    chk(o_set_data[6:0], sdcd_pkg::MPC_RDFIFO, "fifo opcode");
    send(sdcd_pkg::SDCD_CMD_MPC, 3'h0, 1'b0, 1'b0, 1'b0, 7'h20, 6'h00);
    send(sdcd_pkg::SDCD_CMD_ROW_OPEN, 3'h4, 1'b0, 1'b0, 1'b0, 7'h00, 6'h00);
    chk(o_cmd_banks, 8'h10, "row open bank");
    chk(o_seq_error, 1'b0, "no pairing fault");
    i_stop_req = 1'b1;
    n = 0;
    while (o_clk_stopped !== 1'b1 && n < 40) begin
      @(negedge i_ref_clk);
      n++;
    end
    repeat (5) @(negedge i_ref_clk);
    chk({o_clk_stopped, o_ready}, 2'h2, "stopped, not ready");
    i_stop_req = 1'b0;
    n = 0;
    while (o_ready !== 1'b1 && n < 50) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk(n >= sdcd_pkg::READY_CYC && n <= sdcd_pkg::READY_CYC + 8, 1'b1, "ready delay");
    send(sdcd_pkg::SDCD_CMD_WRITE, 3'h3, 1'b0, 1'b0, 1'b0, 7'h00, 6'h07);
    chk(o_column, 10'h070, "write after restart");
    tally_and_finish();
  end
endmodule : tb
